// ==== rtl/mcmsl_pkg.sv ====
// Package of constants for the motor mode and speed limit block
package mcmsl_pkg;
    localparam logic [7:0] ADDR_MODE      = 8'h00;
    localparam logic [7:0] ADDR_MAXSPD0   = 8'h01;
    localparam logic [7:0] ADDR_MAXSPD1   = 8'h02;
    localparam logic [7:0] ADDR_MAXSPD2   = 8'h03;
    localparam logic [7:0] ADDR_POLES     = 8'h04;
    localparam logic [7:0] ADDR_ENC_PPR   = 8'h05;
    localparam logic [7:0] ADDR_TRQ_GAIN  = 8'h06;
    localparam logic [7:0] ADDR_OPTBITS   = 8'h07;
    localparam logic [7:0] ADDR_STATUS    = 8'h08;
    localparam logic [7:0] ADDR_IRQ_STAT  = 8'h09;
    localparam logic [7:0] ADDR_IRQ_MASK  = 8'h0a;
    localparam logic [7:0] ADDR_EFF_SPD   = 8'h0b;
    localparam logic [7:0] ADDR_FAULT     = 8'h0c;

    localparam logic [1:0] MODE_SPEED_EXPRESS = 2'h0;
    localparam logic [1:0] MODE_SPEED         = 2'h1;
    localparam logic [1:0] MODE_TORQUE        = 2'h2;

    localparam logic [7:0]  FAULT_CODE_CFG = 8'h31;
    localparam int          ELEC_FREQ_HZ   = 300;
    localparam int          ENC_FREQ_HZ    = 10000;
    localparam logic [19:0] POLE_RPM_NUM   = 20'h08ca0;
    localparam logic [19:0] ENC_RPM_NUM    = 20'h927c0;
    localparam logic [15:0] FW_MAX_RPM     = 16'h1f40;
    localparam logic [15:0] RST_MAXSPD     = 16'h0bb8;
    localparam logic [7:0]  RST_POLES      = 8'h04;
    localparam logic [15:0] RST_ENC_PPR    = 16'h0080;

    localparam int OPT_PUMP_BIT     = 0;
    localparam int OPT_METRIC_BIT   = 5;
    localparam int ST_FAULT_BIT     = 0;
    localparam int ST_TORQUE_BIT    = 1;
    localparam int ST_DRIVE_BIT     = 2;
    localparam int ST_BUSY_BIT      = 3;
    localparam int IRQ_FAULT_BIT    = 0;
    localparam int IRQ_LIMIT_BIT    = 1;
    localparam int IRQ_WIDTH        = 2;
endpackage

// ==== rtl/mcmsl_div.sv ====
// Sequential unsigned divider for speed limit calculation
`timescale 1ns/1ps
module mcmsl_div #(
    parameter int NW = 20,
    parameter int DW = 16
) (
    input  wire logic          mclk,
    input  wire logic          rst,
    input  wire logic          start,
    input  wire logic [NW-1:0] num,
    input  wire logic [DW-1:0] den,
    output logic      [NW-1:0] quo,
    output logic               done
);
    if (NW < DW || NW > 31) begin : g_bad_width
        $error("mcmsl_div width unsupported");
    end
    localparam int CW = $clog2(NW + 1);
    logic [NW-1:0] q_reg;
    logic [NW:0]   r_reg;
    logic [DW-1:0] d_reg;
    logic [CW-1:0] cnt_reg;
    logic          busy_reg;
    wire  [NW:0]   shifted = {r_reg[NW-1:0], q_reg[NW-1]};
    wire  [NW:0]   dext    = {{(NW-DW+1){1'b0}}, d_reg};
    wire           ge      = shifted >= dext;
    wire  [NW:0]   sub     = shifted - dext;
    always_ff @(posedge mclk) begin
        if (rst) begin
            q_reg <= '0;
            r_reg <= '0;
            d_reg <= '0;
            cnt_reg <= '0;
            busy_reg <= 1'b0;
            done <= 1'b0;
            quo <= '0;
        end else begin
            done <= 1'b0;
            if (start && !busy_reg) begin
                q_reg <= num;
                r_reg <= '0;
                d_reg <= (den == '0) ? {{(DW-1){1'b0}}, 1'b1} : den;
                cnt_reg <= CW'(NW);
                busy_reg <= 1'b1;
            end else if (busy_reg) begin
                r_reg <= ge ? sub : shifted;
                q_reg <= {q_reg[NW-2:0], ge};
                cnt_reg <= cnt_reg - 1'b1;
                if (cnt_reg == CW'(1)) begin
                    busy_reg <= 1'b0;
                    done <= 1'b1;
                    quo <= {q_reg[NW-2:0], ge};
                end
            end
        end
    end
endmodule

// ==== rtl/mcmsl_limit.sv ====
// Minimum of the three speed limits and the per-mode maximum
`timescale 1ns/1ps
module mcmsl_limit (
    input  wire logic [19:0] pole_lim,
    input  wire logic [19:0] enc_lim,
    input  wire logic [15:0] mode_max,
    output logic      [15:0] eff_max
);
    function automatic logic [19:0] min20(input logic [19:0] a,
                                          input logic [19:0] b);
        min20 = (a < b) ? a : b;
    endfunction
    wire [19:0] fw20  = {4'h0, mcmsl_pkg::FW_MAX_RPM};
    wire [19:0] m20   = {4'h0, mode_max};
    wire [19:0] hw    = min20(min20(pole_lim, enc_lim), fw20);
    wire [19:0] all20 = min20(hw, m20);
    assign eff_max = all20[15:0];
endmodule

// ==== rtl/mcmsl_top.sv ====
// Drive mode selection, configuration fault and speed limiting
`timescale 1ns/1ps
module mcmsl_top (
    input  wire logic        mclk,
    input  wire logic        rst,
    input  wire logic        pwr_on_rst,
    input  wire logic [7:0]  addr,
    input  wire logic [15:0] wdata,
    input  wire logic        wr,
    input  wire logic        rd,
    output logic      [15:0] rdata,
    input  wire logic [15:0] throttle,
    input  wire logic        drive_req,
    output logic      [15:0] speed_cmd,
    output logic      [15:0] torque_cmd,
    output logic      [15:0] speed_limit,
    output logic             drive_en,
    output logic             irq
);
    typedef enum logic [1:0] {ST_IDLE, ST_POLE, ST_ENC} mcmsl_calc_t;
    mcmsl_calc_t calc_reg;
    localparam int IRQW = mcmsl_pkg::IRQ_WIDTH;

    logic [1:0]  mode_reg;
    logic [15:0] maxspd_reg [3];
    logic [7:0]  poles_reg;
    logic [15:0] enc_reg;
    logic [15:0] trq_gain_reg;
    logic [7:0]  opt_reg;
    logic        fault_reg;
    logic [IRQW-1:0] irq_stat_reg;
    logic [IRQW-1:0] irq_mask_reg;
    logic [19:0] pole_lim_reg;
    logic [19:0] enc_lim_reg;
    logic        recalc_reg;
    logic [15:0] limit_prev_reg;

    wire wr_mode  = wr && addr == mcmsl_pkg::ADDR_MODE;
    wire wr_poles = wr && addr == mcmsl_pkg::ADDR_POLES;
    wire wr_enc   = wr && addr == mcmsl_pkg::ADDR_ENC_PPR;
    wire [1:0] wmode = wdata[1:0];
    wire mode_ok  = wmode <= mcmsl_pkg::MODE_TORQUE && wdata[15:2] == '0;
    wire mode_chg = wr_mode && mode_ok && wmode != mode_reg;
    wire is_torque = mode_reg == mcmsl_pkg::MODE_TORQUE;
    wire busy = calc_reg != ST_IDLE;

    logic        div_start;
    logic [19:0] div_num;
    logic [15:0] div_den;
    logic [19:0] div_quo;
    logic        div_done;
    logic [15:0] eff_max;

    assign div_start = (calc_reg == ST_IDLE && recalc_reg) ||
                       (calc_reg == ST_POLE && div_done);
    assign div_num = (calc_reg == ST_IDLE) ? mcmsl_pkg::POLE_RPM_NUM
                                           : mcmsl_pkg::ENC_RPM_NUM;
    assign div_den = (calc_reg == ST_IDLE) ? {8'h00, poles_reg} : enc_reg;

    mcmsl_div #(.NW(20), .DW(16)) u_div (
        .mclk  (mclk),
        .rst   (rst),
        .start (div_start),
        .num   (div_num),
        .den   (div_den),
        .quo   (div_quo),
        .done  (div_done)
    );

    mcmsl_limit u_lim (
        .pole_lim (pole_lim_reg),
        .enc_lim  (enc_lim_reg),
        .mode_max (maxspd_reg[mode_reg]),
        .eff_max  (eff_max)
    );

    wire [31:0] req_prod = throttle * speed_limit;
    wire [15:0] spd_next = is_torque ? 16'h0000 : req_prod[31:16];
    wire [15:0] trq_next = is_torque ? throttle : 16'h0000;
    wire drive_next = drive_req && !fault_reg;
    wire [IRQW-1:0] ev;
    assign ev[mcmsl_pkg::IRQ_FAULT_BIT] = mode_chg && !fault_reg;
    assign ev[mcmsl_pkg::IRQ_LIMIT_BIT] = speed_limit != limit_prev_reg;
    wire rd_irq = rd && addr == mcmsl_pkg::ADDR_IRQ_STAT;

    logic [15:0] status_w;
    always_comb begin
        status_w = '0;
        status_w[mcmsl_pkg::ST_FAULT_BIT]  = fault_reg;
        status_w[mcmsl_pkg::ST_TORQUE_BIT] = is_torque;
        status_w[mcmsl_pkg::ST_DRIVE_BIT]  = drive_en;
        status_w[mcmsl_pkg::ST_BUSY_BIT]   = busy;
    end

    logic [15:0] rd_mux;
    always_comb begin
        case (addr)
            mcmsl_pkg::ADDR_MODE:     rd_mux = {14'h0000, mode_reg};
            mcmsl_pkg::ADDR_MAXSPD0:  rd_mux = maxspd_reg[0];
            mcmsl_pkg::ADDR_MAXSPD1:  rd_mux = maxspd_reg[1];
            mcmsl_pkg::ADDR_MAXSPD2:  rd_mux = maxspd_reg[2];
            mcmsl_pkg::ADDR_POLES:    rd_mux = {8'h00, poles_reg};
            mcmsl_pkg::ADDR_ENC_PPR:  rd_mux = enc_reg;
            mcmsl_pkg::ADDR_TRQ_GAIN: rd_mux = trq_gain_reg;
            mcmsl_pkg::ADDR_OPTBITS:  rd_mux = {8'h00, opt_reg};
            mcmsl_pkg::ADDR_STATUS:   rd_mux = status_w;
            mcmsl_pkg::ADDR_IRQ_STAT: rd_mux = {14'h0000, irq_stat_reg};
            mcmsl_pkg::ADDR_IRQ_MASK: rd_mux = {14'h0000, irq_mask_reg};
            mcmsl_pkg::ADDR_EFF_SPD:  rd_mux = speed_limit;
            mcmsl_pkg::ADDR_FAULT:    rd_mux = fault_reg ?
                {8'h00, mcmsl_pkg::FAULT_CODE_CFG} : 16'h0000;
            default:                  rd_mux = 16'h0000;
        endcase
    end

    // Power-on latch: only the power-on reset clears it
    always_ff @(posedge mclk) begin
        if (pwr_on_rst) begin
            fault_reg <= 1'b0;
        end else if (mode_chg) begin
            fault_reg <= 1'b1;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            mode_reg <= mcmsl_pkg::MODE_SPEED_EXPRESS;
            poles_reg <= mcmsl_pkg::RST_POLES;
            enc_reg <= mcmsl_pkg::RST_ENC_PPR;
            trq_gain_reg <= '0;
            opt_reg <= '0;
            irq_mask_reg <= '0;
        end else if (wr) begin
            if (wr_mode && mode_ok) mode_reg <= wmode;
            if (wr_poles) poles_reg <= wdata[7:0];
            if (wr_enc) enc_reg <= wdata;
            if (addr == mcmsl_pkg::ADDR_TRQ_GAIN) trq_gain_reg <= wdata;
            if (addr == mcmsl_pkg::ADDR_OPTBITS) opt_reg <= wdata[7:0];
            if (addr == mcmsl_pkg::ADDR_IRQ_MASK) irq_mask_reg <= wdata[IRQW-1:0];
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++) begin : g_max
            always_ff @(posedge mclk) begin
                if (rst) begin
                    maxspd_reg[gi] <= mcmsl_pkg::RST_MAXSPD;
                end else if (wr && addr == mcmsl_pkg::ADDR_MAXSPD0 + 8'(gi)) begin
                    maxspd_reg[gi] <= wdata;
                end
            end
        end
    endgenerate

    always_ff @(posedge mclk) begin
        if (rst) begin
            calc_reg <= ST_IDLE;
            recalc_reg <= 1'b1;
            pole_lim_reg <= '0;
            enc_lim_reg <= '0;
        end else begin
            if (wr_poles || wr_enc) recalc_reg <= 1'b1;
            else if (calc_reg == ST_IDLE) recalc_reg <= 1'b0;
            case (calc_reg)
                ST_IDLE: if (recalc_reg) calc_reg <= ST_POLE;
                ST_POLE: if (div_done) begin
                    pole_lim_reg <= div_quo;
                    calc_reg <= ST_ENC;
                end
                ST_ENC: if (div_done) begin
                    enc_lim_reg <= div_quo;
                    calc_reg <= ST_IDLE;
                end
                default: calc_reg <= ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            irq_stat_reg <= '0;
            limit_prev_reg <= '0;
            irq <= 1'b0;
        end else begin
            limit_prev_reg <= speed_limit;
            irq_stat_reg <= (rd_irq ? '0 : irq_stat_reg) | ev;
            irq <= |(((rd_irq ? '0 : irq_stat_reg) | ev) & irq_mask_reg);
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            rdata <= '0;
            speed_cmd <= '0;
            torque_cmd <= '0;
            speed_limit <= '0;
            drive_en <= 1'b0;
        end else begin
            rdata <= rd ? rd_mux : 16'h0000;
            speed_limit <= busy ? 16'h0000 : eff_max;
            speed_cmd <= drive_next ? spd_next : 16'h0000;
            torque_cmd <= drive_next ? trq_next : 16'h0000;
            drive_en <= drive_next;
        end
    end

    a_fault_sticky: assert property (@(posedge mclk) disable iff (pwr_on_rst)
        fault_reg |=> fault_reg) else $error("fault cleared");
    a_fault_set: assert property (@(posedge mclk) disable iff (pwr_on_rst)
        mode_chg |=> fault_reg) else $error("fault not set");
    a_drive_inhibit: assert property (@(posedge mclk) disable iff (rst)
        fault_reg |=> !drive_en) else $error("drive while fault");
    a_ceiling: assert property (@(posedge mclk) disable iff (rst)
        speed_limit <= mcmsl_pkg::FW_MAX_RPM) else $error("over ceiling");
    a_pole_cap: assert property (@(posedge mclk) disable iff (rst)
        {4'h0, speed_limit} <= pole_lim_reg) else $error("over pole");
    a_enc_cap: assert property (@(posedge mclk) disable iff (rst)
        {4'h0, speed_limit} <= enc_lim_reg) else $error("over enc");
    a_torque_spd: assert property (@(posedge mclk) disable iff (rst)
        is_torque && !fault_reg ##1 is_torque |-> speed_cmd == 16'h0000)
        else $error("speed in torque");
    a_speed_trq: assert property (@(posedge mclk) disable iff (rst)
        !is_torque ##1 !is_torque |-> torque_cmd == 16'h0000)
        else $error("torque in speed");
    a_mode_legal: assert property (@(posedge mclk) disable iff (rst)
        mode_reg <= mcmsl_pkg::MODE_TORQUE) else $error("bad mode");
endmodule

// ==== dv/mcmsl_motor_model.sv ====
// Motor model that asks for drive and watches the commands it receives
`timescale 1ns/1ps
module mcmsl_motor_model (
    input  wire logic        mclk,
    input  wire logic        run,
    input  wire logic        drive_en,
    input  wire logic [15:0] speed_cmd,
    input  wire logic [15:0] torque_cmd,
    input  wire logic [15:0] speed_limit,
    output logic             drive_req,
    output int               viol
);
    initial begin
        drive_req = 1'b0;
        viol      = 0;
    end
    always @(posedge mclk) begin
        // Drive is asked for only when the bench allows it
        drive_req <= run;
        // A speed request never exceeds the effective limit
        if (drive_en === 1'b1 && speed_cmd > speed_limit) begin
            viol <= viol + 1;
        end
        // Only one kind of request at a time
        if (speed_cmd !== 16'h0000 && torque_cmd !== 16'h0000) begin
            viol <= viol + 1;
        end
    end
endmodule

// ==== dv/tb.sv ====
// Self-checking bench for the mode and speed limit block
`timescale 1ns/1ps
module tb;
    logic        mclk       = 1'b0;
    logic        rst        = 1'b1;
    logic        pwr_on_rst = 1'b1;
    logic [7:0]  addr       = 8'h00;
    logic [15:0] wdata      = 16'h0000;
    logic        wr         = 1'b0;
    logic        rd         = 1'b0;
    logic [15:0] throttle   = 16'h0000;
    logic        run        = 1'b0;
    logic        drive_req;
    logic [15:0] rdata;
    logic [15:0] speed_cmd;
    logic [15:0] torque_cmd;
    logic [15:0] speed_limit;
    logic        drive_en;
    logic        irq;
    int          viol;
    int          n_fail     = 0;
    int          num_checks = 0;
    int          cyc        = 0;
    int          tp[3]      = '{4, 6, 4};
    int          te[3]      = '{128, 1, 75};

    mcmsl_top dut_u (.mclk(mclk), .rst(rst), .pwr_on_rst(pwr_on_rst),
        .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
        .throttle(throttle), .drive_req(drive_req), .speed_cmd(speed_cmd),
        .torque_cmd(torque_cmd), .speed_limit(speed_limit),
        .drive_en(drive_en), .irq(irq));

    mcmsl_motor_model motor_u (.mclk(mclk), .run(run), .drive_en(drive_en),
        .speed_cmd(speed_cmd), .torque_cmd(torque_cmd),
        .speed_limit(speed_limit), .drive_req(drive_req), .viol(viol));

    initial begin
        forever #2.5 mclk = ~mclk;
    end

    function automatic logic [15:0] lim_exp(int p, int e, int m);
        int l;
        l = 36000 / p;
        if (600000 / e < l) l = 600000 / e;
        if (8000 < l) l = 8000;
        if (m < l) l = m;
        return 16'(l);
    endfunction

    task automatic chk(string nm, logic [15:0] e, logic [15:0] g);
        num_checks++;
        if (g !== e) begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic wr_reg(logic [7:0] a, logic [15:0] v);
        @(posedge mclk);
        addr  <= a;
        wdata <= v;
        wr    <= 1'b1;
        @(posedge mclk);
        wr    <= 1'b0;
    endtask

    task automatic rd_chk(string nm, logic [7:0] a, logic [15:0] e,
                          logic [15:0] m);
        @(posedge mclk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge mclk);
        rd   <= 1'b0;
        #1;
        chk(nm, e & m, rdata & m);
    endtask

    task automatic wait_lim();
        int n;
        repeat (3) @(posedge mclk);
        n = 0;
        while (speed_limit === 16'h0000 && n < 200) begin
            @(posedge mclk);
            n++;
        end
        // A write taken mid-calculation queues a second pass
        repeat (3) @(posedge mclk);
        while (speed_limit === 16'h0000 && n < 400) begin
            @(posedge mclk);
            n++;
        end
        #1;
    endtask

    task automatic settle(int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask

    task automatic print_verdict();
        $display("Checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    always @(posedge mclk) begin
        cyc++;
        if (cyc == 20000) begin
            n_fail++;
            $display("ERROR cycle_limit expected 0 seen %0d", cyc);
            print_verdict();
        end
    end

    initial begin
        repeat (4) @(posedge mclk);
        rst        <= 1'b0;
        pwr_on_rst <= 1'b0;
        wait_lim();
        chk("limit_default", lim_exp(4, 128, 3000), speed_limit);
        wr_reg(mcmsl_pkg::ADDR_MAXSPD0, 16'h1f40);
        for (int i = 0; i < 3; i++) begin
            wr_reg(mcmsl_pkg::ADDR_POLES, 16'(tp[i]));
            wr_reg(mcmsl_pkg::ADDR_ENC_PPR, 16'(te[i]));
            wait_lim();
            rd_chk("eff_speed", mcmsl_pkg::ADDR_EFF_SPD,
                   lim_exp(tp[i], te[i], 8000), 16'hffff);
            chk("elec_freq", 16'h1,
                16'(int'(speed_limit) * tp[i] / 120 <= 300));
        end
        chk("ceiling", 16'h1f40, speed_limit);
        $display("test limits done");
        @(posedge mclk);
        throttle <= 16'hffff;
        run      <= 1'b1;
        settle(5);
        chk("drive_en", 16'h1, 16'(drive_en));
        chk("speed_cmd", 16'((65535 * 8000) >> 16), speed_cmd);
        chk("torque_cmd", 16'h0000, torque_cmd);
        wr_reg(mcmsl_pkg::ADDR_TRQ_GAIN, 16'h1234);
        rd_chk("trq_gain", mcmsl_pkg::ADDR_TRQ_GAIN, 16'h1234, 16'hffff);
        chk("speed_cmd_gain", 16'((65535 * 8000) >> 16), speed_cmd);
        wr_reg(mcmsl_pkg::ADDR_OPTBITS, 16'h0021);
        rd_chk("opt_bits", mcmsl_pkg::ADDR_OPTBITS, 16'h0021, 16'h00ff);
        rd_chk("unmapped", 8'h20, 16'h0000, 16'hffff);
        wr_reg(mcmsl_pkg::ADDR_MODE, 16'h0003);
        wr_reg(mcmsl_pkg::ADDR_MODE, 16'h0000);
        rd_chk("mode_kept", mcmsl_pkg::ADDR_MODE, 16'h0000, 16'h0003);
        rd_chk("no_fault", mcmsl_pkg::ADDR_FAULT, 16'h0000, 16'h00ff);
        $display("test speed mode done");
        @(posedge mclk);
        run <= 1'b0;
        wr_reg(mcmsl_pkg::ADDR_IRQ_MASK, 16'h0001);
        rd_chk("irq_pre", mcmsl_pkg::ADDR_IRQ_STAT, 16'h0000, 16'h0001);
        wr_reg(mcmsl_pkg::ADDR_MODE, 16'h0002);
        settle(2);
        chk("irq_fault", 16'h1, 16'(irq));
        rd_chk("fault_code", mcmsl_pkg::ADDR_FAULT, 16'h0031, 16'h00ff);
        rd_chk("irq_stat", mcmsl_pkg::ADDR_IRQ_STAT, 16'h0001, 16'h0001);
        settle(2);
        chk("irq_clear", 16'h0, 16'(irq));
        @(posedge mclk);
        run <= 1'b1;
        settle(5);
        chk("drive_inhibit", 16'h0, 16'(drive_en));
        chk("torque_inhibit", 16'h0000, torque_cmd);
        wr_reg(mcmsl_pkg::ADDR_FAULT, 16'h0000);
        rd_chk("fault_wr", mcmsl_pkg::ADDR_FAULT, 16'h0031, 16'h00ff);
        @(posedge mclk);
        rst <= 1'b1;
        repeat (2) @(posedge mclk);
        rst <= 1'b0;
        wait_lim();
        rd_chk("fault_rst", mcmsl_pkg::ADDR_FAULT, 16'h0031, 16'h00ff);
        $display("test fault done");
        wr_reg(mcmsl_pkg::ADDR_MODE, 16'h0002);
        @(posedge mclk);
        pwr_on_rst <= 1'b1;
        @(posedge mclk);
        pwr_on_rst <= 1'b0;
        throttle   <= 16'h1234;
        wait_lim();
        settle(5);
        rd_chk("fault_pwr", mcmsl_pkg::ADDR_FAULT, 16'h0000, 16'h00ff);
        rd_chk("torque_stat", mcmsl_pkg::ADDR_STATUS, 16'h0006, 16'h0007);
        chk("torque_cmd", 16'h1234, torque_cmd);
        chk("speed_cmd_trq", 16'h0000, speed_cmd);
        chk("motor_viol", 16'h0000, 16'(viol));
        $display("test torque mode done");
        print_verdict();
    end
endmodule
